/* pfr_power_fail_reset_manager.sv */
// Power-fail, power-on and watchdog reset manager with power mode control
// Operation
// [R1] Enabled power-fail warning requests an interrupt vectoring to 33h.
// [R2] Power-fail flag sets below warning, sticks, and re-sets while low persists.
// [R3] Software writing one to power-fail flag raises an interrupt if enabled.
// [R4] Supply below reset threshold forces reset, except Stop with bandgap select clear.
// [R5] Power-up waits above reset threshold, then counts 65,536 clocks, restarting on dips.
// [R6] External clock source starts the count equally once above reset threshold.
// [R7] Count completion releases reset automatically; fetch starts at 0000h.
// [R8] Power-on flag, bit 6, set by power-up, cleared only by software.
// [R9] Entering Stop disables bandgap monitor unless bandgap select bit is one.
// [R10] Watchdog interrupt flag sets on each timeout; cleared by software or reset.
// [R11] Watchdog reset enabled asserts reset 512 clocks after timeout unless restarted.
// [R12] Watchdog reset flag set on watchdog reset; cleared by software or power-fail reset.
// [R13] Watchdog reset enable gates reset only; interrupt needs its own enable.
// [R14] Restart strobe bit 0 restarts watchdog period and self-clears.
// [R15] Ring select leaves Stop on ring oscillator, switches to crystal after 65,536 cycles.
// [R16] Ring status bit reads one on ring oscillator, zero on crystal.
// [R17] Without ring select, execution waits 65,536 crystal clocks after Stop.
// [R18] Ring select cleared only by power-on reset; the code also clears it when software writes zero to bit 1.
// [R19] Power control bit 1 enters Stop, halting execution and clocks.
// [R20] Power control bit 0 enters Idle, halting execution only.
// [R21] Watchdog cannot wake the device from Stop.
// [R22] Enabled interrupt or any reset ends Idle and clears the idle bit.
// [R23] Power-fail interrupt request is flag AND enable.
`timescale 1ns/100ps
module pfr_power_fail_reset_manager #(
  parameter int STARTUP_CLOCKS = pfr_pkg::STARTUP_CLOCKS,
  parameter int WD_RESET_DELAY = pfr_pkg::WD_RESET_DELAY
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Analog supply monitor comparators
  input wire pfr_pkg::pfr_supply_t supply_in,
  // Watchdog timer and external events
  input wire logic watchdog_timeout,
  input wire logic ext_reset,
  input wire logic wake_irq,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Core side
  output pfr_pkg::pfr_core_t core_out,
  output logic [15:0] reset_vector,
  output logic watchdog_restart,
  output logic bandgap_enable,
  output logic ring_osc_status
);
  localparam int WDW = $clog2(WD_RESET_DELAY + 1);
  localparam logic [WDW-1:0] WD_LAST = WDW'(WD_RESET_DELAY - 1);

  pfr_pkg::pfr_supply_t supply_s;
  pfr_pkg::pfr_state_t state_reg;
  logic por_done;
  logic stop_done;
  logic startup_restart;
  logic power_reset;
  logic monitor_on;
  logic wr_watchdog_power_control;
  logic wr_ext_flags_osc_select;
  logic wr_power_control;
  logic wr_eie;
  logic powerfail_flag_reg;
  logic powerfail_irq_enable_reg;
  logic power_on_flag_reg;
  logic watchdog_irq_flag_reg;
  logic watchdog_reset_flag_reg;
  logic watchdog_reset_enable_reg;
  logic watchdog_irq_enable_reg;
  logic bandgap_in_stop_select_reg;
  logic ring_osc_select_reg;
  logic ring_osc_status_reg;
  logic idle_reg;
  logic stop_reg;
  logic stop_wait_reg;
  logic wd_armed_reg;
  logic [WDW-1:0] wd_cnt_reg;
  logic wd_reset_reg;
  logic any_reset;
  logic [7:0] eie_rest_reg;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_addr);
    hit = (a == ref_addr);
  endfunction

  pfr_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .async_in(supply_in),
    .sync_out(supply_s)
  );

  assign wr_watchdog_power_control = reg_wr && hit(reg_addr, pfr_pkg::ADDR_WATCHDOG_POWER_CONTROL);
  assign wr_ext_flags_osc_select = reg_wr && hit(reg_addr, pfr_pkg::ADDR_EXT_FLAGS);
  assign wr_power_control = reg_wr && hit(reg_addr, pfr_pkg::ADDR_POWER_CONTROL);
  assign wr_eie = reg_wr && hit(reg_addr, pfr_pkg::ADDR_EXT_IRQ_ENABLE);

  // Monitor off in Stop unless bandgap select set
  assign monitor_on = !stop_reg || bandgap_in_stop_select_reg; // [R9]
  // Supply low forces reset, cannot be disabled outside Stop
  assign power_reset = supply_s.below_reset && monitor_on; // [R4]
  // Any supply dip restarts the count; oscillator or external clock alike
  assign startup_restart = power_reset || state_reg == pfr_pkg::PFR_ST_OFF; // [R5] [R6]
  assign any_reset = power_reset || state_reg != pfr_pkg::PFR_ST_RUN || wd_reset_reg || ext_reset;

  pfr_counter #(
    .COUNT(STARTUP_CLOCKS)
  ) u_por_cnt (
    .clk(clk),
    .srst(srst),
    .restart(startup_restart),
    .run(1'b1),
    .done(por_done)
  );

  pfr_counter #(
    .COUNT(STARTUP_CLOCKS)
  ) u_stop_cnt (
    .clk(clk),
    .srst(srst),
    .restart(!stop_wait_reg),
    .run(1'b1),
    .done(stop_done)
  );

  // Power-up sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= pfr_pkg::PFR_ST_OFF;
    end else begin
      case (state_reg)
        pfr_pkg::PFR_ST_OFF: begin
          if (!power_reset) begin
            state_reg <= pfr_pkg::PFR_ST_COUNT; // [R5]
          end
        end
        pfr_pkg::PFR_ST_COUNT: begin
          if (power_reset) begin
            state_reg <= pfr_pkg::PFR_ST_OFF; // [R5]
          end else if (por_done) begin
            state_reg <= pfr_pkg::PFR_ST_RUN; // [R7]
          end
        end
        pfr_pkg::PFR_ST_RUN: begin
          if (power_reset) begin
            state_reg <= pfr_pkg::PFR_ST_OFF; // [R4]
          end
        end
        default: state_reg <= pfr_pkg::PFR_ST_OFF;
      endcase
    end
  end

  // Power-fail flag and enable
  always_ff @(posedge clk) begin
    if (srst) begin
      powerfail_flag_reg <= 1'b0;
      powerfail_irq_enable_reg <= 1'b0;
    end else begin
      if (wr_watchdog_power_control) begin
        powerfail_irq_enable_reg <= reg_wdata[pfr_pkg::PF_IRQ_EN_BIT];
      end
      // Low supply wins over a software clear; writing one forces it
      if (supply_s.below_warning && monitor_on) begin
        powerfail_flag_reg <= 1'b1; // [R2]
      end else if (wr_watchdog_power_control) begin
        powerfail_flag_reg <= reg_wdata[pfr_pkg::PF_FLAG_BIT]; // [R3]
      end
    end
  end

  // Power-on flag, only software clears it
  always_ff @(posedge clk) begin
    if (srst) begin
      power_on_flag_reg <= 1'b1;
    end else if (state_reg == pfr_pkg::PFR_ST_OFF) begin
      power_on_flag_reg <= 1'b1; // [R8]
    end else if (wr_watchdog_power_control && !reg_wdata[pfr_pkg::POR_FLAG_BIT]) begin
      power_on_flag_reg <= 1'b0; // [R8]
    end
  end

  // Watchdog control bits and flags
  always_ff @(posedge clk) begin
    if (srst) begin
      watchdog_irq_flag_reg <= 1'b0;
      watchdog_reset_flag_reg <= 1'b0;
      watchdog_reset_enable_reg <= 1'b0;
      watchdog_restart <= 1'b0;
      watchdog_irq_enable_reg <= 1'b0;
      eie_rest_reg <= pfr_pkg::REG_RESET;
    end else begin
      watchdog_restart <= wr_watchdog_power_control && reg_wdata[pfr_pkg::WD_RESTART_BIT]; // [R14]
      if (wr_eie) begin
        watchdog_irq_enable_reg <= reg_wdata[pfr_pkg::WD_IRQ_EN_BIT];
        eie_rest_reg <= reg_wdata & ~(8'h01 << pfr_pkg::WD_IRQ_EN_BIT);
      end
      if (power_reset || state_reg != pfr_pkg::PFR_ST_RUN) begin
        watchdog_reset_enable_reg <= 1'b0;
      end else if (wr_watchdog_power_control) begin
        watchdog_reset_enable_reg <= reg_wdata[pfr_pkg::WD_RESET_EN_BIT];
      end
      // Timeout sets flag regardless of interrupt enable; set wins over clear
      if (watchdog_timeout && !stop_reg) begin
        watchdog_irq_flag_reg <= 1'b1; // [R10] [R21]
      end else if (any_reset) begin
        watchdog_irq_flag_reg <= 1'b0; // [R10]
      end else if (wr_watchdog_power_control) begin
        watchdog_irq_flag_reg <= reg_wdata[pfr_pkg::WD_IRQ_FLAG_BIT]; // [R10]
      end
      if (wd_reset_reg) begin
        watchdog_reset_flag_reg <= 1'b1; // [R12]
      end else if (power_reset) begin
        watchdog_reset_flag_reg <= 1'b0; // [R12]
      end else if (wr_watchdog_power_control) begin
        watchdog_reset_flag_reg <= reg_wdata[pfr_pkg::WD_RESET_FLAG_BIT]; // [R12]
      end
    end
  end

  // Reset delay after watchdog timeout, gated by reset enable, not interrupt enable; restart, Stop or any reset cancels it
  always_ff @(posedge clk) begin
    if (srst) begin
      wd_armed_reg <= 1'b0;
      wd_cnt_reg <= '0;
      wd_reset_reg <= 1'b0;
    end else begin
      wd_reset_reg <= 1'b0;
      if (!watchdog_reset_enable_reg || watchdog_restart || stop_reg || any_reset) begin
        wd_armed_reg <= 1'b0; // [R13] [R14] [R21]
        wd_cnt_reg <= '0;
      end else if (watchdog_timeout && !wd_armed_reg) begin
        wd_armed_reg <= 1'b1;
        wd_cnt_reg <= '0;
      end else if (wd_armed_reg) begin
        wd_cnt_reg <= wd_cnt_reg + WDW'(1);
        if (wd_cnt_reg == WD_LAST) begin
          wd_reset_reg <= 1'b1; // [R11]
          wd_armed_reg <= 1'b0;
        end
      end
    end
  end

  // Bandgap and ring oscillator select
  always_ff @(posedge clk) begin
    if (srst) begin
      bandgap_in_stop_select_reg <= 1'b0;
      ring_osc_select_reg <= 1'b0;
    end else if (state_reg == pfr_pkg::PFR_ST_OFF) begin
      bandgap_in_stop_select_reg <= 1'b0;
      ring_osc_select_reg <= 1'b0; // [R18]
    end else if (any_reset) begin
      bandgap_in_stop_select_reg <= 1'b0;
    end else if (wr_ext_flags_osc_select) begin
      bandgap_in_stop_select_reg <= reg_wdata[pfr_pkg::BANDGAP_SEL_BIT]; // [R9]
      ring_osc_select_reg <= reg_wdata[pfr_pkg::RING_SEL_BIT];
    end
  end

  // Idle, Stop and wake-up clock source
  always_ff @(posedge clk) begin
    if (srst) begin
      idle_reg <= 1'b0;
      stop_reg <= 1'b0;
      stop_wait_reg <= 1'b0;
      ring_osc_status_reg <= 1'b0;
    end else if (any_reset) begin
      idle_reg <= 1'b0; // [R22]
      stop_reg <= 1'b0;
      stop_wait_reg <= 1'b0;
      ring_osc_status_reg <= 1'b0;
    end else begin
      if (wr_power_control) begin
        idle_reg <= reg_wdata[pfr_pkg::IDLE_BIT]; // [R20]
        stop_reg <= reg_wdata[pfr_pkg::STOP_BIT]; // [R19]
      end else if (stop_reg && wake_irq) begin
        stop_reg <= 1'b0;
        idle_reg <= 1'b0;
        stop_wait_reg <= 1'b1;
        ring_osc_status_reg <= ring_osc_select_reg; // [R15] [R16]
      end else if (idle_reg && core_out.powerfail_irq | core_out.watchdog_irq | wake_irq) begin
        idle_reg <= 1'b0; // [R22]
      end
      if (stop_wait_reg && stop_done) begin
        stop_wait_reg <= 1'b0;
        ring_osc_status_reg <= 1'b0; // [R15] [R16]
      end
    end
  end

  // Core side outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      core_out <= '0;
      reset_vector <= pfr_pkg::RESET_VECTOR;
      bandgap_enable <= 1'b1;
      ring_osc_status <= 1'b0;
    end else begin
      core_out.core_reset <= any_reset; // [R4] [R7] [R11]
      // Crystal wake holds execution until the startup delay ends
      core_out.core_hold <= stop_wait_reg && !ring_osc_status_reg && !stop_done; // [R17]
      core_out.idle_mode <= idle_reg;
      core_out.stop_mode <= stop_reg;
      core_out.powerfail_irq <= powerfail_flag_reg && powerfail_irq_enable_reg; // [R1] [R23]
      core_out.watchdog_irq <= watchdog_irq_flag_reg && watchdog_irq_enable_reg; // [R13]
      // Vector follows the same next value as the interrupt output, so both change together
      reset_vector <= (powerfail_flag_reg && powerfail_irq_enable_reg) ? pfr_pkg::PF_VECTOR
                                                                       : pfr_pkg::RESET_VECTOR; // [R1] [R7]
      bandgap_enable <= monitor_on; // [R9]
      ring_osc_status <= ring_osc_status_reg; // [R16]
    end
  end

  // Register read port
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= pfr_pkg::REG_RESET;
    end else if (reg_rd) begin
      case (reg_addr)
        pfr_pkg::ADDR_WATCHDOG_POWER_CONTROL: begin
          reg_rdata <= {1'b0, power_on_flag_reg, powerfail_irq_enable_reg, powerfail_flag_reg,
                        watchdog_irq_flag_reg, watchdog_reset_flag_reg, watchdog_reset_enable_reg, 1'b0};
        end
        pfr_pkg::ADDR_EXT_FLAGS: begin
          reg_rdata <= {5'h00, ring_osc_status_reg, ring_osc_select_reg, bandgap_in_stop_select_reg}; // [R16]
        end
        pfr_pkg::ADDR_POWER_CONTROL: reg_rdata <= {6'h00, stop_reg, idle_reg};
        pfr_pkg::ADDR_EXT_IRQ_ENABLE: reg_rdata <= eie_rest_reg | {3'h0, watchdog_irq_enable_reg, 4'h0};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule // pfr_power_fail_reset_manager

/* pfr_pkg.sv */
// Package with register map, field positions, reset values and counts for the power-fail reset manager
package pfr_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_EXT_FLAGS = 8'h91;
  localparam logic [7:0] ADDR_WATCHDOG_POWER_CONTROL = 8'hD8;
  localparam logic [7:0] ADDR_EXT_IRQ_ENABLE = 8'hE8;
  // Field positions in the watchdog power control register
  localparam int WD_RESTART_BIT = 0;
  localparam int WD_RESET_EN_BIT = 1;
  localparam int WD_RESET_FLAG_BIT = 2;
  localparam int WD_IRQ_FLAG_BIT = 3;
  localparam int PF_FLAG_BIT = 4;
  localparam int PF_IRQ_EN_BIT = 5;
  localparam int POR_FLAG_BIT = 6;
  // Field positions in the extended flags register
  localparam int BANDGAP_SEL_BIT = 0;
  localparam int RING_SEL_BIT = 1;
  localparam int RING_STATUS_BIT = 2;
  // Field positions in the power control and extended enable registers
  localparam int IDLE_BIT = 0;
  localparam int STOP_BIT = 1;
  localparam int WD_IRQ_EN_BIT = 4;
  // Values and counts
  localparam logic [15:0] PF_VECTOR = 16'h0033;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam int STARTUP_CLOCKS = 65536;
  localparam int WD_RESET_DELAY = 512;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Startup sequencer states, Gray coded
  typedef enum logic [1:0] {
    PFR_ST_OFF = 2'b00,
    PFR_ST_COUNT = 2'b01,
    PFR_ST_RUN = 2'b11
  } pfr_state_t;
  // Analog monitor inputs
  typedef struct packed {
    logic below_warning;
    logic below_reset;
  } pfr_supply_t;
  // Requests toward the core
  typedef struct packed {
    logic core_reset;
    logic core_hold;
    logic idle_mode;
    logic stop_mode;
    logic powerfail_irq;
    logic watchdog_irq;
  } pfr_core_t;
endpackage

/* pfr_sync.sv */
// Three-stage synchroniser with agreement check for asynchronous inputs
`timescale 1ns/100ps
module pfr_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Output changes only once the second and third stages agree
  always_ff @(posedge clk) begin
    if (srst) begin
      sync_out <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          sync_out[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule // pfr_sync

/* pfr_counter.sv */
// Restartable startup delay counter
`timescale 1ns/100ps
module pfr_counter #(
  parameter int COUNT = 65536
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control
  input wire logic restart,
  input wire logic run,
  // Status
  output logic done
);
  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);
  logic [CW-1:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (srst || restart) begin
      cnt_reg <= '0;
      done <= 1'b0;
    end else if (run && !done) begin
      cnt_reg <= cnt_reg + CW'(1);
      done <= (cnt_reg == LAST);
    end
  end
endmodule // pfr_counter

/* pfr_supply_model.sv */
// Behavioural model of the analog supply comparators
`timescale 1ns/100ps
module pfr_supply_model (
  // Wanted supply state
  input wire logic want_warn,
  input wire logic want_rst,
  // Comparator levels
  output pfr_pkg::pfr_supply_t supply
);
  // Powered off at start, so both comparators report low supply
  initial supply = 2'b11;
  // Comparators change off the clock grid; below reset implies below warning
  always @(want_warn or want_rst) begin
    supply.below_warning <= #13 want_warn | want_rst;
    supply.below_reset <= #13 want_rst;
  end
endmodule // pfr_supply_model

/* pfr_checker_sva.sv */
// Port assertions for the power-fail reset manager
`timescale 1ns/100ps
module pfr_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Inputs
  input wire pfr_pkg::pfr_supply_t supply_in,
  input wire logic watchdog_timeout,
  input wire logic ext_reset,
  input wire logic wake_irq,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  // Outputs
  input wire logic [7:0] reg_rdata,
  input wire pfr_pkg::pfr_core_t core_out,
  input wire logic [15:0] reset_vector,
  input wire logic watchdog_restart,
  input wire logic bandgap_enable,
  input wire logic ring_osc_status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_low_supply;
    (supply_in.below_reset && bandgap_enable) [*6];
  endsequence
  sequence s_stop_wake;
    core_out.stop_mode && wake_irq;
  endsequence
  sequence s_restart_write;
    reg_wr && reg_addr == pfr_pkg::ADDR_WATCHDOG_POWER_CONTROL && reg_wdata[0];
  endsequence
  a_low_forces_reset: assert property (s_low_supply |-> core_out.core_reset)
    else $error("no core reset on low supply");
  a_vector_pf: assert property (core_out.powerfail_irq |-> reset_vector == 16'h0033)
    else $error("wrong power-fail vector");
  a_vector_zero: assert property (!core_out.powerfail_irq |-> reset_vector == 16'h0000)
    else $error("wrong reset vector");
  a_restart_cause: assert property (watchdog_restart |-> $past(reg_wr && reg_wdata[0]))
    else $error("restart pulse without write");
  a_restart_follow: assert property (s_restart_write |=> watchdog_restart)
    else $error("restart pulse missing");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  a_bandgap_stop: assert property (!bandgap_enable |-> core_out.stop_mode || $past(core_out.stop_mode))
    else $error("bandgap off outside stop");
  a_stop_wake: assert property (s_stop_wake |-> ##[1:3] !core_out.stop_mode)
    else $error("stop not left on wake");
  a_idle_wake: assert property (core_out.idle_mode && wake_irq |-> ##[1:3] !core_out.idle_mode)
    else $error("idle not left on interrupt");
  a_reset_idle: assert property (core_out.core_reset |=> !core_out.idle_mode)
    else $error("idle kept during reset");
  a_ext_reset: assert property (ext_reset |-> ##[1:3] core_out.core_reset)
    else $error("external reset ignored");
  a_hold_ring: assert property (!(core_out.core_hold && ring_osc_status))
    else $error("hold while on ring oscillator");
  a_stop_wdog: assert property (core_out.stop_mode && watchdog_timeout && !wake_irq && !ext_reset
    |=> core_out.stop_mode)
    else $error("watchdog woke stop");
endmodule // pfr_checker

/* test_power_fail_reset_manager.sv */
// Testbench for the power-fail reset manager
`timescale 1ns/100ps
module test_power_fail_reset_manager;
  localparam int STARTUP = 16;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic want_warn = 1'b1;
  logic want_rst = 1'b1;
  pfr_pkg::pfr_supply_t supply_in;
  logic watchdog_timeout = 1'b0;
  logic ext_reset = 1'b0;
  logic wake_irq = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  pfr_pkg::pfr_core_t core_out;
  logic [15:0] reset_vector;
  logic watchdog_restart, bandgap_enable, ring_osc_status;
  logic rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] rnd;
  int n_fail = 0;
  int n_checks = 0;
  int n;
  always #25 clk = ~clk;
  pfr_supply_model MODEL (.want_warn(want_warn), .want_rst(want_rst), .supply(supply_in));
  pfr_power_fail_reset_manager #(.STARTUP_CLOCKS(STARTUP), .WD_RESET_DELAY(8)) DUT (
    .clk(clk), .srst(srst), .supply_in(supply_in), .watchdog_timeout(watchdog_timeout),
    .ext_reset(ext_reset), .wake_irq(wake_irq), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_out(core_out),
    .reset_vector(reset_vector), .watchdog_restart(watchdog_restart),
    .bandgap_enable(bandgap_enable), .ring_osc_status(ring_osc_status));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    watchdog_timeout <= (k == 0);
    wake_irq <= (k == 1);
    ext_reset <= (k == 2);
    @(posedge clk);
    {watchdog_timeout, wake_irq, ext_reset} <= 3'b000;
  endtask
  task automatic wait_release();
    n = 0;
    while (core_out.core_reset !== 1'b0 && n < 300) begin
      settle(1);
      n++;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Read data is compared with the oldest queued note
  always @(posedge clk) begin
    if (rd_seen)
      chk("read data", {8'h00, exp_q.pop_front()}, {8'h00, reg_rdata});
    rd_seen <= reg_rd;
  end
  initial begin
    #(50 * 6000);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    rnd = $urandom(32'h74c995ec);
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    // Power-up with a dip during the count
    @(posedge clk);
    want_rst <= 1'b0;
    want_warn <= 1'b0;
    settle(8);
    chk("reset in count", 16'h1, {15'h0, core_out.core_reset});
    @(posedge clk);
    want_rst <= 1'b1;
    settle(6);
    @(posedge clk);
    want_rst <= 1'b0;
    wait_release();
    chk("startup cycles", 16'h1, {15'h0, n >= STARTUP && n <= STARTUP + 10});
    chk("vector", 16'h0000, reset_vector);
    rd(8'hD8, 8'h50);
    rd(8'h91, 8'h00);
    rd(8'h87, 8'h00);
    rd(8'h55, 8'h00);
    wr(8'hD8, 8'h40);
    rd(8'hD8, 8'h40);
    wr(8'hD8, 8'h00);
    rd(8'hD8, 8'h00);
    rnd = $urandom();
    wr(8'hE8, rnd);
    rd(8'hE8, rnd);
    $display("test power-up done");
    // Power-fail warning
    @(posedge clk);
    want_warn <= 1'b1;
    settle(8);
    rd(8'hD8, 8'h10);
    chk("pf irq off", 16'h0, {15'h0, core_out.powerfail_irq});
    wr(8'hD8, 8'h20);
    settle(3);
    chk("pf irq", 16'h1, {15'h0, core_out.powerfail_irq});
    chk("pf vector", 16'h0033, reset_vector);
    rd(8'hD8, 8'h30);
    @(posedge clk);
    want_warn <= 1'b0;
    settle(8);
    wr(8'hD8, 8'h20);
    settle(2);
    chk("pf irq cleared", 16'h0, {15'h0, core_out.powerfail_irq});
    rd(8'hD8, 8'h20);
    wr(8'hD8, 8'h30);
    settle(2);
    chk("pf irq forced", 16'h1, {15'h0, core_out.powerfail_irq});
    wr(8'hD8, 8'h10);
    settle(2);
    chk("pf irq masked", 16'h0, {15'h0, core_out.powerfail_irq});
    $display("test power-fail done");
    // Watchdog without reset, then with restart, then reset
    wr(8'hE8, 8'h00);
    wr(8'hD8, 8'h00);
    pulse(0);
    settle(14);
    chk("no wd reset", 16'h0, {15'h0, core_out.core_reset});
    chk("wd irq masked", 16'h0, {15'h0, core_out.watchdog_irq});
    rd(8'hD8, 8'h08);
    wr(8'hE8, 8'h10);
    settle(2);
    chk("wd irq", 16'h1, {15'h0, core_out.watchdog_irq});
    wr(8'hD8, 8'h02);
    pulse(0);
    rd(8'hD8, 8'h0A);
    wr(8'hD8, 8'h03);
    #1;
    chk("restart pulse", 16'h1, {15'h0, watchdog_restart});
    settle(14);
    chk("restarted", 16'h0, {15'h0, core_out.core_reset});
    rd(8'hD8, 8'h02);
    pulse(0);
    settle(8);
    chk("wd reset early", 16'h0, {15'h0, core_out.core_reset});
    settle(1);
    chk("wd reset", 16'h1, {15'h0, core_out.core_reset});
    wait_release();
    rd(8'hD8, 8'h06);
    $display("test watchdog done");
    // Idle entry and exit
    wr(8'h87, 8'h01);
    settle(2);
    chk("idle", 16'h1, {15'h0, core_out.idle_mode});
    pulse(1);
    settle(3);
    chk("idle left", 16'h0, {15'h0, core_out.idle_mode});
    rd(8'h87, 8'h00);
    $display("test idle done");
    // Stop on ring oscillator with bandgap off
    wr(8'h91, 8'h02);
    wr(8'h87, 8'h02);
    settle(2);
    chk("stop", 16'h1, {15'h0, core_out.stop_mode});
    chk("bandgap off", 16'h0, {15'h0, bandgap_enable});
    @(posedge clk);
    want_rst <= 1'b1;
    pulse(0);
    settle(10);
    chk("no reset in stop", 16'h0, {15'h0, core_out.core_reset});
    chk("stop kept", 16'h1, {15'h0, core_out.stop_mode});
    want_rst <= 1'b0;
    settle(8);
    pulse(1);
    settle(2);
    chk("ring status", 16'h1, {15'h0, ring_osc_status});
    chk("no hold on ring", 16'h0, {15'h0, core_out.core_hold});
    settle(30);
    chk("crystal", 16'h0, {15'h0, ring_osc_status});
    rd(8'h91, 8'h02);
    // Stop on crystal with bandgap kept
    wr(8'h91, 8'h01);
    wr(8'h87, 8'h02);
    settle(2);
    chk("bandgap kept", 16'h1, {15'h0, bandgap_enable});
    pulse(1);
    settle(2);
    chk("hold", 16'h1, {15'h0, core_out.core_hold});
    settle(30);
    chk("hold done", 16'h0, {15'h0, core_out.core_hold});
    wr(8'h91, 8'h03);
    pulse(2);
    settle(2);
    wait_release();
    rd(8'h91, 8'h02);
    settle(2);
    $display("test stop done");
    tally_and_finish();
  end
endmodule // test_power_fail_reset_manager
bind pfr_power_fail_reset_manager pfr_checker u_chk (.clk(clk), .srst(srst), .supply_in(supply_in),
  .watchdog_timeout(watchdog_timeout), .ext_reset(ext_reset), .wake_irq(wake_irq), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_out(core_out),
  .reset_vector(reset_vector), .watchdog_restart(watchdog_restart), .bandgap_enable(bandgap_enable),
  .ring_osc_status(ring_osc_status));
